// ==== shared/dfdp_params.svh ====
// Constants for the disk formatter drive port
`ifndef DFDP_PARAMS_SVH
`define DFDP_PARAMS_SVH
`define DFDP_MODE_SEQ_OUT_BIT   6
`define DFDP_MODE_HARD_SEC_BIT  7
`define DFDP_MODE_RESET         8'h00
`define DFDP_CTRL_IO_BIT        2
`define DFDP_SYNC_STAGES        2
`endif

// ==== shared/dfdp_pkg.sv ====
// Types for the disk formatter drive port
package dfdp_pkg;
	typedef enum logic [1:0] {
		DFDP_IDLE,
		DFDP_READ,
		DFDP_WRITE
	} dfdp_state_e;
	typedef logic [7:0] dfdp_byte_t;
endpackage

// ==== design/dfdp_drive_port.sv ====
// Drive-side pin logic of the disk formatter
// Function
// - Mode bit six sets general line direction
// - Input level of general line reaches sequencer
// - Output general line follows control bit two
// - General line is input after reset
// - Mode bit seven picks hard or soft sector
// - Soft sector mode by default
// - Soft sector mode: low mark line during read means mark
// - Hard sector mode: mark line is sector input
// - Read gate high while taking read data
// - Write gate high while sending write data
// - NRZ is input while read gate high
// - NRZ driven out while write gate high
// - NRZ data moves on drive reference clock
// - Reset halts work and drops both gates
// - Reset floats every bidirectional line
`timescale 1ns/10ps
`include "dfdp_params.svh"
module dfdp_drive_port (
	// Clock and reset
	input  wire logic            clock_in,
	input  wire logic            rstn_in,
	// Sequencer side
	input  wire dfdp_pkg::dfdp_byte_t mode_in,
	input  wire dfdp_pkg::dfdp_byte_t ctrl_field_in,
	input  wire logic            read_req_in,
	input  wire logic            write_req_in,
	input  wire logic            write_bit_in,
	input  wire logic            write_mark_in,
	output logic                 gp_level_out,
	output logic                 read_bit_out,
	output logic                 read_bit_valid_out,
	output logic                 write_bit_taken_out,
	output logic                 mark_detect_out,
	output logic                 sector_pulse_out,
	output logic                 index_pulse_out,
	output logic                 read_active_out,
	output logic                 write_active_out,
	// Drive pins
	input  wire logic            ref_clk_in,
	input  wire logic            index_in,
	input  wire logic            gp_line_in,
	output logic                 gp_line_out,
	output logic                 gp_line_oe_out,
	input  wire logic            mark_sector_line_in,
	output logic                 write_mark_out_n,
	output logic                 mark_sector_oe_out,
	input  wire logic            nrz_in,
	output logic                 nrz_out,
	output logic                 nrz_oe_out,
	output logic                 read_gate_out,
	output logic                 write_gate_out
);
	import dfdp_pkg::*;

	localparam int NS = `DFDP_SYNC_STAGES;

	// Two-stage synchronisers for every pin input
	logic [NS-1:0] s_ref, s_idx, s_gp, s_ms, s_nrz;
	logic [NS-1:0] next_s_ref, next_s_idx, next_s_gp, next_s_ms, next_s_nrz;
	logic          ref_d, idx_d, ms_d;
	logic          next_ref_d, next_idx_d, next_ms_d;

	always_comb begin
		next_s_ref = {s_ref[NS-2:0], ref_clk_in};
		next_s_idx = {s_idx[NS-2:0], index_in};
		next_s_gp  = {s_gp[NS-2:0], gp_line_in};
		next_s_ms  = {s_ms[NS-2:0], mark_sector_line_in};
		next_s_nrz = {s_nrz[NS-2:0], nrz_in};
		next_ref_d = s_ref[NS-1];
		next_idx_d = s_idx[NS-1];
		next_ms_d  = s_ms[NS-1];
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_ref <= '0;
			s_idx <= '0;
			s_gp  <= '0;
			s_ms  <= '1;
			s_nrz <= '0;
			ref_d <= 1'b0;
			idx_d <= 1'b0;
			ms_d  <= 1'b1;
		end else begin
			s_ref <= next_s_ref;
			s_idx <= next_s_idx;
			s_gp  <= next_s_gp;
			s_ms  <= next_s_ms;
			s_nrz <= next_s_nrz;
			ref_d <= next_ref_d;
			idx_d <= next_idx_d;
			ms_d  <= next_ms_d;
		end
	end

	// Edges seen only on the synchronised copies
	logic ref_rise, ref_fall, idx_rise, ms_rise_hard;
	assign ref_rise = s_ref[NS-1] & ~ref_d;
	assign ref_fall = ~s_ref[NS-1] & ref_d;
	assign idx_rise = s_idx[NS-1] & ~idx_d;
	assign ms_rise_hard = s_ms[NS-1] & ~ms_d;

	// Gate state machine
	dfdp_state_e state, next_state;
	logic hard_sec, gp_is_out;
	assign hard_sec  = mode_in[`DFDP_MODE_HARD_SEC_BIT];
	assign gp_is_out = mode_in[`DFDP_MODE_SEQ_OUT_BIT];

	// Gates only open on a clock fall so NRZ never sees a half bit; they drop as soon as the request goes low
	always_comb begin
		next_state = state;
		unique case (state)
			DFDP_IDLE: begin
				if (ref_fall && read_req_in && !write_req_in) begin
					next_state = DFDP_READ;
				end else if (ref_fall && write_req_in && !read_req_in) begin
					next_state = DFDP_WRITE;
				end
			end
			DFDP_READ: begin
				if (!read_req_in) begin
					next_state = DFDP_IDLE;
				end
			end
			DFDP_WRITE: begin
				if (!write_req_in) begin
					next_state = DFDP_IDLE;
				end
			end
		endcase
	end

	// Registered outputs
	logic next_read_gate, next_write_gate, next_nrz_o, next_nrz_oe, next_rbit, next_rvalid, next_wtaken;
	logic next_mark, next_sector, next_index, next_gp_level, next_gp_o, next_gp_oe;
	logic next_mark_n, next_ms_oe;
	logic in_read, in_write;
	assign in_read  = (next_state == DFDP_READ);
	assign in_write = (next_state == DFDP_WRITE);

	always_comb begin
		// A single state value makes both gates together impossible
		next_read_gate  = in_read;
		next_write_gate = in_write;
		next_nrz_oe = in_write;
		next_nrz_o  = nrz_out;
		next_wtaken = 1'b0;
		if (in_write && ref_fall) begin
			next_nrz_o  = write_bit_in;
			next_wtaken = 1'b1;
		end else if (!in_write) begin
			next_nrz_o  = 1'b0;
		end
		next_rbit   = read_bit_out;
		next_rvalid = 1'b0;
		if (state == DFDP_READ && ref_rise) begin
			next_rbit   = s_nrz[NS-1];
			next_rvalid = 1'b1;
		end
		next_mark   = !hard_sec && state == DFDP_READ && !s_ms[NS-1];
		next_sector = hard_sec && ms_rise_hard;
		next_index  = idx_rise;
		// Soft-sector writes drive the mark line only inside a write
		next_ms_oe  = !hard_sec && in_write;
		next_mark_n = !(next_ms_oe && write_mark_in);
		next_gp_oe  = gp_is_out;
		next_gp_o   = gp_is_out & ctrl_field_in[`DFDP_CTRL_IO_BIT];
		next_gp_level = gp_is_out ? gp_line_out : s_gp[NS-1];
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state               <= DFDP_IDLE;
			read_gate_out       <= 1'b0;
			write_gate_out      <= 1'b0;
			nrz_out             <= 1'b0;
			nrz_oe_out          <= 1'b0;
			read_bit_out        <= 1'b0;
			read_bit_valid_out  <= 1'b0;
			write_bit_taken_out <= 1'b0;
			mark_detect_out     <= 1'b0;
			sector_pulse_out    <= 1'b0;
			index_pulse_out     <= 1'b0;
			write_mark_out_n    <= 1'b1;
			mark_sector_oe_out  <= 1'b0;
			gp_line_out         <= 1'b0;
			gp_line_oe_out      <= 1'b0;
			gp_level_out        <= 1'b0;
			read_active_out     <= 1'b0;
			write_active_out    <= 1'b0;
		end else begin
			state               <= next_state;
			read_gate_out       <= next_read_gate;
			write_gate_out      <= next_write_gate;
			nrz_out             <= next_nrz_o;
			nrz_oe_out          <= next_nrz_oe;
			read_bit_out        <= next_rbit;
			read_bit_valid_out  <= next_rvalid;
			write_bit_taken_out <= next_wtaken;
			mark_detect_out     <= next_mark;
			sector_pulse_out    <= next_sector;
			index_pulse_out     <= next_index;
			write_mark_out_n    <= next_mark_n;
			mark_sector_oe_out  <= next_ms_oe;
			gp_line_out         <= next_gp_o;
			gp_line_oe_out      <= next_gp_oe;
			gp_level_out        <= next_gp_level;
			read_active_out     <= next_read_gate;
			write_active_out    <= next_write_gate;
		end
	end

	// Checks
	sequence s_write_gate_up;
		write_gate_out && nrz_oe_out;
	endsequence

	a_gates_exclusive: assert property (@(posedge clock_in) disable iff (!rstn_in)
		!(read_gate_out && write_gate_out)) else $error("read and write gates high together");
	a_nrz_drive_write: assert property (@(posedge clock_in) disable iff (!rstn_in)
		write_gate_out |-> s_write_gate_up) else $error("nrz not driven during write");
	a_nrz_float_read: assert property (@(posedge clock_in) disable iff (!rstn_in)
		read_gate_out |-> !nrz_oe_out) else $error("nrz driven during read");
	a_gp_direction: assert property (@(posedge clock_in) disable iff (!rstn_in)
		gp_line_oe_out == $past(gp_is_out)) else $error("general line direction wrong");
	a_gp_follow: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$past(gp_is_out) |-> gp_line_out == $past(ctrl_field_in[`DFDP_CTRL_IO_BIT]))
		else $error("general line output wrong");
	a_mark_soft: assert property (@(posedge clock_in) disable iff (!rstn_in)
		mark_detect_out |-> $past(!hard_sec && read_gate_out)) else $error("mark outside soft read");
	a_sector_input: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$past(hard_sec) |-> !mark_sector_oe_out) else $error("mark line driven in hard mode");
	a_write_gate_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(write_gate_out && write_req_in) |=> write_gate_out) else $error("write gate dropped early");
	a_read_gate_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(read_gate_out && read_req_in) |=> read_gate_out) else $error("read gate dropped early");
	a_index_sync: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$rose(index_pulse_out) |-> $past(s_idx[NS-1])) else $error("index pulse without synced edge");

	// Gate entry, one edge after the synced clock fall
	sequence s_take_write;
		state == DFDP_IDLE && ref_fall && write_req_in && !read_req_in;
	endsequence
	sequence s_take_read;
		state == DFDP_IDLE && ref_fall && read_req_in && !write_req_in;
	endsequence
	sequence s_write_shift;
		write_gate_out && write_req_in && ref_fall;
	endsequence
	sequence s_read_shift;
		read_gate_out && ref_rise;
	endsequence

	a_write_enter: assert property (@(posedge clock_in) disable iff (!rstn_in)
		s_take_write |=> write_gate_out && nrz_oe_out && write_bit_taken_out) else $error("write gate not opened");
	a_read_enter: assert property (@(posedge clock_in) disable iff (!rstn_in)
		s_take_read |=> read_gate_out && !nrz_oe_out) else $error("read gate not opened");
	a_write_drop: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(write_gate_out && !write_req_in) |=> !write_gate_out && !nrz_oe_out) else $error("write gate held");
	a_read_drop: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(read_gate_out && !read_req_in) |=> !read_gate_out) else $error("read gate held");
	a_read_sample: assert property (@(posedge clock_in) disable iff (!rstn_in)
		s_read_shift |=> read_bit_valid_out && read_bit_out == $past(s_nrz[NS-1])) else $error("read bit lost");
	a_valid_in_read: assert property (@(posedge clock_in) disable iff (!rstn_in)
		read_bit_valid_out |-> $past(read_gate_out)) else $error("read bit outside read gate");
	a_write_launch: assert property (@(posedge clock_in) disable iff (!rstn_in)
		s_write_shift |=> write_bit_taken_out && nrz_out == $past(write_bit_in)) else $error("write bit not sent");
	a_taken_on_fall: assert property (@(posedge clock_in) disable iff (!rstn_in)
		write_bit_taken_out |-> $past(ref_fall)) else $error("write bit off the clock fall");
	a_gate_on_fall: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$rose(write_gate_out) |-> $past(ref_fall)) else $error("write gate off the clock fall");
	a_gp_level_in: assert property (@(posedge clock_in) disable iff (!rstn_in)
		!$past(gp_is_out) |-> gp_level_out == $past(s_gp[NS-1])) else $error("general line level lost");
	a_sector_pulse: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(hard_sec && ms_rise_hard) |=> sector_pulse_out) else $error("sector pulse missed");
	a_sector_soft: assert property (@(posedge clock_in) disable iff (!rstn_in)
		sector_pulse_out |-> $past(hard_sec)) else $error("sector pulse in soft mode");
	a_mark_oe_write: assert property (@(posedge clock_in) disable iff (!rstn_in)
		mark_sector_oe_out |-> write_gate_out) else $error("mark line driven outside write");
	a_mark_level: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(!hard_sec && read_gate_out && !s_ms[NS-1]) |=> mark_detect_out) else $error("mark missed");
	a_index_pulse: assert property (@(posedge clock_in) disable iff (!rstn_in)
		idx_rise |=> index_pulse_out) else $error("index pulse missed");
	a_active_copy: assert property (@(posedge clock_in) disable iff (!rstn_in)
		read_active_out == read_gate_out && write_active_out == write_gate_out) else $error("active copy wrong");
endmodule

// ==== sim/dfdp_drive_model.sv ====
// Drive channel model: reference clock, NRZ read data and mark line
`timescale 1ns/10ps
module dfdp_drive_model (
	// Device side of the pins
	input  wire logic read_gate_in,
	input  wire logic nrz_dev_in,
	input  wire logic nrz_oe_in,
	input  wire logic mark_dev_n_in,
	input  wire logic mark_oe_in,
	// Bench control
	input  wire logic data_in,
	input  wire logic mark_low_in,
	// Drive pins
	output logic      ref_clk_out,
	output logic      drive_bit_out,
	output wire logic nrz_pin_out,
	output wire logic mark_pin_out
);
	logic last = 1'h0;
	initial begin
		ref_clk_out = 1'h0;
		forever #80 ref_clk_out = ~ref_clk_out;
	end
	always @(negedge ref_clk_out) begin
		drive_bit_out <= data_in;
		last <= nrz_pin_out;
	end
	// Released line toggles so a stale value never looks valid
	assign nrz_pin_out = nrz_oe_in ? nrz_dev_in : (read_gate_in ? drive_bit_out : ~last);
	// Pulled up; the drive only pulls low for a mark or a sector pulse
	assign mark_pin_out = mark_oe_in ? mark_dev_n_in : ~mark_low_in;
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the drive port
`timescale 1ns/10ps
`include "dfdp_params.svh"
module tb_top;
	import dfdp_pkg::*;
	logic clock_in = 1'h0, rstn_in = 1'h0;
	dfdp_byte_t mode_in = `DFDP_MODE_RESET, ctrl_field_in = 8'h00;
	logic read_req_in = 1'h0, write_req_in = 1'h0, write_bit_in = 1'h0, write_mark_in = 1'h0;
	logic index_in = 1'h0, gp_drv = 1'h0, data_in = 1'h0, mark_low_in = 1'h0;
	logic gp_level_out, read_bit_out, read_bit_valid_out, write_bit_taken_out, mark_detect_out;
	logic sector_pulse_out, index_pulse_out, read_active_out, write_active_out, gp_line_out, gp_line_oe_out;
	logic write_mark_out_n, mark_sector_oe_out, nrz_out, nrz_oe_out, read_gate_out, write_gate_out;
	wire logic ref_clk_in, nrz_in, mark_sector_line_in, gp_line_in, drive_bit;
	int errors = 0, checks = 0, seed = 89602, nsec = 0, nidx = 0;
	logic q[$];
	task automatic chk(input logic got, input logic exp, input string msg);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	initial forever #10 clock_in = ~clock_in;
	initial begin
		#500000;
		errors++;
		final_report();
	end
	assign gp_line_in = gp_line_oe_out ? gp_line_out : gp_drv;
	dfdp_drive_port DUT (.clock_in, .rstn_in, .mode_in, .ctrl_field_in, .read_req_in, .write_req_in,
		.write_bit_in, .write_mark_in, .gp_level_out, .read_bit_out, .read_bit_valid_out, .write_bit_taken_out,
		.mark_detect_out, .sector_pulse_out, .index_pulse_out, .read_active_out, .write_active_out,
		.ref_clk_in, .index_in, .gp_line_in, .gp_line_out, .gp_line_oe_out, .mark_sector_line_in,
		.write_mark_out_n, .mark_sector_oe_out, .nrz_in, .nrz_out, .nrz_oe_out, .read_gate_out, .write_gate_out);
	dfdp_drive_model M (.read_gate_in(read_gate_out), .nrz_dev_in(nrz_out), .nrz_oe_in(nrz_oe_out),
		.mark_dev_n_in(write_mark_out_n), .mark_oe_in(mark_sector_oe_out), .data_in, .mark_low_in,
		.ref_clk_out(ref_clk_in), .drive_bit_out(drive_bit), .nrz_pin_out(nrz_in), .mark_pin_out(mark_sector_line_in));
	always @(posedge ref_clk_in) if (read_gate_out) q.push_back(drive_bit);
	// Drive samples a write bit at the fall after launch, clear of the next launch
	always @(negedge ref_clk_in) if (nrz_oe_out && write_gate_out && q.size() > 0) chk(nrz_in, q.pop_front(), "wbit");
	always @(negedge clock_in) begin
		if (write_bit_taken_out) q.push_back(write_bit_in);
		write_bit_in = 1'($random(seed));
		data_in = 1'($random(seed));
	end
	always @(posedge clock_in) begin
		#1;
		if (read_bit_valid_out && q.size() > 0) chk(read_bit_out, q.pop_front(), "rbit");
		if (read_gate_out && write_gate_out) chk(1'h0, 1'h1, "both gates");
		nsec += int'(sector_pulse_out);
		nidx += int'(index_pulse_out);
	end
	initial begin
		cyc(3);
		chk(read_gate_out | write_gate_out | nrz_oe_out | mark_sector_oe_out | gp_line_oe_out, 1'h0, "rst");
		chk(write_mark_out_n, 1'h1, "rst mark");
		cyc(13);
		rstn_in = 1'h1;
		cyc(2);
		chk(gp_line_oe_out | mark_sector_oe_out, 1'h0, "defaults");
		$display("reset test done");
		write_req_in = 1'h1;
		cyc(60);
		write_mark_in = 1'h1;
		cyc(2);
		chk(mark_sector_line_in, 1'h0, "wmark");
		write_mark_in = 1'h0;
		read_req_in = 1'h1;
		cyc(100);
		chk(write_gate_out & write_active_out & ~read_gate_out, 1'h1, "wgate");
		read_req_in = 1'h0;
		write_req_in = 1'h0;
		cyc(12);
		chk(write_gate_out | nrz_oe_out, 1'h0, "wdrop");
		q.delete();
		$display("write test done");
		read_req_in = 1'h1;
		cyc(40);
		chk(read_gate_out & read_active_out, 1'h1, "ractive");
		mark_low_in = 1'h1;
		cyc(6);
		chk(mark_detect_out, 1'h1, "mark");
		mark_low_in = 1'h0;
		cyc(6);
		chk(mark_detect_out | nrz_oe_out, 1'h0, "no mark");
		cyc(100);
		read_req_in = 1'h0;
		cyc(12);
		chk(read_gate_out, 1'h0, "rdrop");
		q.delete();
		read_req_in = 1'h1;
		write_req_in = 1'h1;
		cyc(30);
		chk(read_gate_out | write_gate_out, 1'h0, "both req");
		read_req_in = 1'h0;
		write_req_in = 1'h0;
		$display("read test done");
		mode_in[`DFDP_MODE_SEQ_OUT_BIT] = 1'h1;
		repeat (8) begin
			ctrl_field_in = 8'($random(seed));
			cyc(2);
			chk(gp_line_oe_out & (gp_line_in === ctrl_field_in[`DFDP_CTRL_IO_BIT]), 1'h1, "gp out");
		end
		mode_in = `DFDP_MODE_RESET;
		repeat (8) begin
			gp_drv = 1'($random(seed));
			cyc(5);
			chk(gp_level_out, gp_drv, "gp in");
		end
		$display("general line test done");
		// Write runs too, so a stray mark drive would mask the sector pulses
		mode_in[`DFDP_MODE_HARD_SEC_BIT] = 1'h1;
		write_req_in = 1'h1;
		repeat (3) begin
			mark_low_in = 1'h1;
			index_in = 1'h1;
			cyc(4);
			mark_low_in = 1'h0;
			index_in = 1'h0;
			cyc(8);
		end
		chk(nsec == 3 && nidx == 3 && !mark_sector_oe_out, 1'h1, "sec idx");
		$display("sector test done");
		rstn_in = 1'h0;
		#1;
		chk(write_gate_out | nrz_oe_out | mark_sector_oe_out, 1'h0, "mid rst");
		q.delete();
		$display("mid reset test done");
		final_report();
	end
endmodule
